// ---- rtl/lpmc_consts.svh ----
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH

// ----------------------------------------------------------------
// Register map (word addresses, Avalon byte address / 4)
// ----------------------------------------------------------------
`define LPMC_ADDR_W          2
`define LPMC_OFS_CTRL_FIRST  2'h0
`define LPMC_OFS_CTRL_SECOND 2'h1
`define LPMC_OFS_STATUS      2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LPMC_F1_STBY         7
`define LPMC_F1_STS_HI       6
`define LPMC_F1_STS_LO       4
`define LPMC_F1_LOW_SPEED_ON_BIT         3
`define LPMC_F2_SUBSLEEP_SELECT_BIT        7
`define LPMC_F2_DIRECT_TRANSITION_BIT         5
`define LPMC_F2_MA_HI        4
`define LPMC_F2_MA_LO        2
`define LPMC_F2_SA_HI        1
`define LPMC_F2_SA_LO        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LPMC_RST_CTRL_FIRST  8'h00
`define LPMC_RST_CTRL_SECOND 8'h00

// ----------------------------------------------------------------
// Timing and mode codes
// ----------------------------------------------------------------
`define LPMC_DT_PROC_CYC     16'h0003
`define LPMC_CNT_W           16
`define LPMC_MODE_ACTIVE     3'h0
`define LPMC_MODE_SUBACT     3'h1
`define LPMC_MODE_SLEEP      3'h2
`define LPMC_MODE_SUBSLEEP   3'h3
`define LPMC_MODE_STANDBY    3'h4
`define LPMC_MODE_OSCWAIT    3'h5
`define LPMC_MODE_DTPROC     3'h6
`define LPMC_MODE_RESET      3'h7

`endif

// ---- rtl/lpmc_pkg.sv ----
package lpmc_pkg;

  typedef enum logic [2:0] {
    S_ACTIVE, S_SUBACT, S_SLEEP, S_SUBSLEEP, S_STANDBY, S_OSCWAIT, S_DTPROC, S_RESET
  } lpmc_state_t;

  // Power control bundle towards clock generator, CPU and ports
  typedef struct packed {
    logic       cpu_run;
    logic       cpu_reset;
    logic       periph_clk_en;
    logic       timer_a_run;
    logic       sys_osc_en;
    logic       io_hiz;
    logic       io_hold;
    logic       clk_src_sub;
    logic [2:0] active_speed;
    logic [1:0] sub_speed;
  } lpmc_pwr_ctl_t;

  // CPU side request bundle
  typedef struct packed {
    logic sleep_exec;
    logic int_mask;
    logic irq_pending;
    logic dt_irq_en;
  } lpmc_cpu_req_t;

endpackage : lpmc_pkg

// ---- rtl/lpmc_top.sv ----
`timescale 1ns/10ps
`include "lpmc_consts.svh"
module lpmc_top #(
  parameter logic [15:0] STBY_WAIT_MAX = 16'h2000
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic [`LPMC_ADDR_W-1:0] avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [31:0]             avs_readdata_out,
  output logic                         avs_waitrequest_out,
  input  wire lpmc_pkg::lpmc_cpu_req_t cpu_req_in,
  input  wire logic                    chip_init_pin_n_in,
  output lpmc_pkg::lpmc_pwr_ctl_t      pwr_ctl_out,
  output logic                         exc_start_out,
  output logic                         dt_exc_start_out,
  output logic                         periph_reset_out
);
  import lpmc_pkg::*;
  lpmc_state_t               state;
  lpmc_state_t               next_state;
  logic [7:0]                power_ctrl_first;
  logic [7:0]                power_ctrl_second;
  logic [2:0]                act_speed_eff;
  logic [1:0]                sub_speed_eff;
  logic                      wake_locked;
  logic                      dt_to_sub;
  logic                      dt_from_sub;
  logic                      dt_pending;
  logic [`LPMC_CNT_W-1:0]    cnt;
  logic                      bus_ack;
  logic                      wake_ok;
  logic                      cnt_done;
  logic                      sleep_go;
  logic                      dt_take;
  logic                      low_speed_on_bit;
  logic                      standby_select_bit;
  logic                      subsleep_select_bit;
  logic                      direct_transition_bit;
  logic [2:0]                standby_timer_field;
  logic [`LPMC_CNT_W-1:0]    stby_wait;
  lpmc_pwr_ctl_t             next_ctl;

  function automatic logic [2:0] mode_code(input lpmc_state_t s);
    unique case (s)
      S_ACTIVE:   mode_code = `LPMC_MODE_ACTIVE;
      S_SUBACT:   mode_code = `LPMC_MODE_SUBACT;
      S_SLEEP:    mode_code = `LPMC_MODE_SLEEP;
      S_SUBSLEEP: mode_code = `LPMC_MODE_SUBSLEEP;
      S_STANDBY:  mode_code = `LPMC_MODE_STANDBY;
      S_OSCWAIT:  mode_code = `LPMC_MODE_OSCWAIT;
      S_DTPROC:   mode_code = `LPMC_MODE_DTPROC;
      S_RESET:    mode_code = `LPMC_MODE_RESET;
    endcase
  endfunction : mode_code
  function automatic lpmc_state_t halt_mode(input logic subsleep);
    halt_mode = subsleep ? S_SUBSLEEP : S_SLEEP;
  endfunction : halt_mode

  assign low_speed_on_bit      = power_ctrl_first[`LPMC_F1_LOW_SPEED_ON_BIT];
  assign standby_select_bit    = power_ctrl_first[`LPMC_F1_STBY];
  assign standby_timer_field   = power_ctrl_first[`LPMC_F1_STS_HI:`LPMC_F1_STS_LO];
  assign subsleep_select_bit   = power_ctrl_second[`LPMC_F2_SUBSLEEP_SELECT_BIT];
  assign direct_transition_bit = power_ctrl_second[`LPMC_F2_DIRECT_TRANSITION_BIT];
  assign stby_wait             = STBY_WAIT_MAX >> standby_timer_field;
  assign cnt_done              = (cnt == '0);
  assign sleep_go = cpu_req_in.sleep_exec && (state == S_ACTIVE || state == S_SUBACT);
  assign wake_ok  = cpu_req_in.irq_pending && !cpu_req_in.int_mask && !wake_locked;
  assign dt_take  = direct_transition_bit && !cpu_req_in.int_mask && cpu_req_in.dt_irq_en;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_ack;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read_in || avs_write_in) && !bus_ack;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      power_ctrl_first  <= `LPMC_RST_CTRL_FIRST;
      power_ctrl_second <= `LPMC_RST_CTRL_SECOND;
    end else if (avs_write_in && bus_ack && avs_byteenable_in[0]) begin
      if (avs_address_in == `LPMC_OFS_CTRL_FIRST) begin
        power_ctrl_first <= avs_writedata_in[7:0];
      end
      if (avs_address_in == `LPMC_OFS_CTRL_SECOND) begin
        power_ctrl_second <= avs_writedata_in[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && !bus_ack) begin
      unique case (avs_address_in)
        `LPMC_OFS_CTRL_FIRST:  avs_readdata_out <= {24'h0, power_ctrl_first};
        `LPMC_OFS_CTRL_SECOND: avs_readdata_out <= {24'h0, power_ctrl_second};
        `LPMC_OFS_STATUS:      avs_readdata_out <= {23'h0, wake_locked, sub_speed_eff,
                                                   act_speed_eff, mode_code(state)};
        default:               avs_readdata_out <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (!chip_init_pin_n_in) begin
      next_state = S_RESET;
    end else begin
      unique case (state)
        S_ACTIVE, S_SUBACT: begin
          if (sleep_go) begin
            if (direct_transition_bit) begin
              next_state = dt_take ? S_DTPROC : halt_mode(subsleep_select_bit);
            end else if (standby_select_bit) begin
              next_state = S_STANDBY;
            end else begin
              next_state = halt_mode(subsleep_select_bit);
            end
          end
        end
        S_SLEEP, S_SUBSLEEP: begin
          if (wake_ok) begin
            next_state = low_speed_on_bit ? S_SUBACT : S_ACTIVE;
          end
        end
        S_STANDBY: begin
          if (wake_ok) begin
            next_state = S_OSCWAIT;
          end
        end
        S_OSCWAIT: begin
          if (cnt_done) begin
            next_state = S_ACTIVE;
          end
        end
        S_DTPROC: begin
          if (cnt_done) begin
            next_state = dt_to_sub ? S_SUBACT : (dt_from_sub ? S_OSCWAIT : S_ACTIVE);
          end
        end
        S_RESET: begin
          next_state = S_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state <= S_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      cnt <= '0;
    end else if (next_state == S_DTPROC && state != S_DTPROC) begin
      cnt <= `LPMC_DT_PROC_CYC - 16'h0001;
    end else if (next_state == S_OSCWAIT && state != S_OSCWAIT) begin
      cnt <= (stby_wait == '0) ? '0 : stby_wait - 16'h0001;
    end else if (!cnt_done) begin
      cnt <= cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      wake_locked   <= 1'b0;
      dt_to_sub     <= 1'b0;
      dt_from_sub   <= 1'b0;
      dt_pending    <= 1'b0;
      act_speed_eff <= 3'h0;
      sub_speed_eff <= 2'h0;
    end else begin
      if (state == S_RESET) begin
        wake_locked <= 1'b0;
      end else if (sleep_go && direct_transition_bit && cpu_req_in.int_mask) begin
        wake_locked <= 1'b1;
      end
      if (sleep_go) begin
        act_speed_eff <= power_ctrl_second[`LPMC_F2_MA_HI:`LPMC_F2_MA_LO];
        sub_speed_eff <= power_ctrl_second[`LPMC_F2_SA_HI:`LPMC_F2_SA_LO];
        dt_to_sub     <= low_speed_on_bit;
        dt_from_sub   <= (state == S_SUBACT);
        dt_pending    <= (next_state == S_DTPROC);
      end else if (next_state == S_ACTIVE || next_state == S_SUBACT) begin
        dt_pending    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    next_ctl              = '0;
    next_ctl.active_speed = act_speed_eff;
    next_ctl.sub_speed    = sub_speed_eff;
    unique case (next_state)
      S_ACTIVE: begin
        next_ctl.cpu_run = 1'b1;
        next_ctl.periph_clk_en = 1'b1;
        next_ctl.timer_a_run = 1'b1;
        next_ctl.sys_osc_en = 1'b1;
      end
      S_SUBACT: begin
        next_ctl.cpu_run = 1'b1;
        next_ctl.periph_clk_en = 1'b1;
        next_ctl.timer_a_run = 1'b1;
        next_ctl.clk_src_sub = 1'b1;
      end
      S_SLEEP: begin
        next_ctl.periph_clk_en = 1'b1;
        next_ctl.timer_a_run = 1'b1;
        next_ctl.sys_osc_en = 1'b1;
      end
      S_SUBSLEEP: begin
        next_ctl.timer_a_run = 1'b1;
        next_ctl.io_hold = 1'b1;
        next_ctl.clk_src_sub = 1'b1;
      end
      S_STANDBY: begin
        next_ctl.io_hiz = 1'b1;
      end
      S_OSCWAIT: begin
        next_ctl.sys_osc_en = 1'b1;
        next_ctl.io_hiz = dt_pending ? 1'b0 : 1'b1;
      end
      S_DTPROC: begin
        next_ctl.periph_clk_en = 1'b1;
        next_ctl.timer_a_run = 1'b1;
        next_ctl.sys_osc_en = !dt_from_sub || !dt_to_sub;
        next_ctl.clk_src_sub = dt_from_sub;
      end
      S_RESET: begin
        next_ctl.cpu_reset = 1'b1;
        next_ctl.sys_osc_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pwr_ctl_out      <= '0;
      exc_start_out    <= 1'b0;
      dt_exc_start_out <= 1'b0;
      periph_reset_out <= 1'b0;
    end else begin
      pwr_ctl_out      <= next_ctl;
      exc_start_out    <= chip_init_pin_n_in && !dt_pending &&
                          (state == S_SLEEP || state == S_SUBSLEEP || state == S_OSCWAIT) &&
                          (next_state == S_ACTIVE || next_state == S_SUBACT);
      dt_exc_start_out <= chip_init_pin_n_in && dt_pending &&
                          (state == S_DTPROC || state == S_OSCWAIT) &&
                          (next_state == S_ACTIVE || next_state == S_SUBACT);
      periph_reset_out <= (next_state != state) && subsleep_select_bit;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence dt_to_sub_go;
    chip_init_pin_n_in && state == S_ACTIVE && sleep_go && dt_take && low_speed_on_bit;
  endsequence
  sequence dt_proc_run;
    (state == S_DTPROC) [*3] ##1 (state == S_SUBACT && dt_exc_start_out);
  endsequence
  a_sleep_cpu_halt: assert property (
    $past(next_state) == S_SLEEP |-> !pwr_ctl_out.cpu_run && pwr_ctl_out.periph_clk_en)
    else $error("sleep control wrong");
  a_sleep_wake_exc: assert property (
    chip_init_pin_n_in && state == S_SLEEP && wake_ok |=> exc_start_out)
    else $error("sleep wake missing");
  a_mask_holds_halt: assert property (
    chip_init_pin_n_in && cpu_req_in.int_mask &&
    (state == S_SLEEP || state == S_SUBSLEEP || state == S_STANDBY) |=> state == $past(state))
    else $error("masked wake");
  a_resume_by_low_speed_on_bit: assert property (
    chip_init_pin_n_in && state == S_SUBSLEEP && wake_ok
    |=> state == ($past(low_speed_on_bit) ? S_SUBACT : S_ACTIVE))
    else $error("wrong resume mode");
  a_pin_reset_cpu: assert property (
    !chip_init_pin_n_in |=> state == S_RESET ##0 pwr_ctl_out.cpu_reset)
    else $error("pin reset missing");
  a_standby_hiz: assert property (
    $past(next_state) == S_STANDBY |-> pwr_ctl_out.io_hiz && !pwr_ctl_out.sys_osc_en)
    else $error("standby ports wrong");
  a_standby_wait: assert property (
    chip_init_pin_n_in && state == S_OSCWAIT && !cnt_done |=> state == S_OSCWAIT && !exc_start_out)
    else $error("settling cut short");
  a_dt_sub_timing: assert property (
    disable iff (!rst_b_in || !chip_init_pin_n_in) dt_to_sub_go |=> dt_proc_run)
    else $error("direct transition timing");
  a_dt_locked: assert property (
    chip_init_pin_n_in && sleep_go && direct_transition_bit && cpu_req_in.int_mask
    |=> (state == S_SLEEP || state == S_SUBSLEEP) && wake_locked)
    else $error("masked direct transition");
  a_sub_speed: assert property (
    $past(sleep_go) |=> pwr_ctl_out.sub_speed == $past(power_ctrl_second[1:0], 2))
    else $error("speed latch wrong");
  a_periph_reset: assert property (
    state != $past(state) && $past(subsleep_select_bit) |-> periph_reset_out)
    else $error("peripheral reset missing");

endmodule : lpmc_top

// ---- verification/lpmc_cpu_model.sv ----
`timescale 1ns/10ps
module lpmc_cpu_model #(
  parameter int PIN_HOLD = 4
) (
  input  wire logic                    core_clk_in,
  input  wire lpmc_pkg::lpmc_pwr_ctl_t pwr_ctl_in,
  input  wire logic                    exc_start_in,
  input  wire logic                    dt_exc_start_in,
  output lpmc_pkg::lpmc_cpu_req_t      cpu_req_out,
  output logic                         chip_init_pin_n_out
);
  import lpmc_pkg::*;
  initial begin
    cpu_req_out = '0;
    chip_init_pin_n_out = 1'b1;
  end
  always @(posedge core_clk_in) begin
    if (exc_start_in === 1'b1 || dt_exc_start_in === 1'b1) begin
      cpu_req_out.irq_pending <= 1'b0;
    end
  end
  task automatic set_flags(input logic mask, input logic dt_en);
    @(posedge core_clk_in);
    cpu_req_out.int_mask <= mask;
    cpu_req_out.dt_irq_en <= dt_en;
  endtask : set_flags
  task automatic sleep_insn();
    @(posedge core_clk_in);
    cpu_req_out.sleep_exec <= 1'b1;
    @(posedge core_clk_in);
    cpu_req_out.sleep_exec <= 1'b0;
  endtask : sleep_insn
  task automatic raise_irq();
    @(posedge core_clk_in);
    cpu_req_out.irq_pending <= 1'b1;
  endtask : raise_irq
  task automatic pin_reset();
    int n;
    n = 0;
    @(posedge core_clk_in);
    chip_init_pin_n_out <= 1'b0;
    cpu_req_out.irq_pending <= 1'b0;
    while (n < PIN_HOLD) begin
      @(posedge core_clk_in);
      if (pwr_ctl_in.sys_osc_en === 1'b1) n++;
    end
    chip_init_pin_n_out <= 1'b1;
  endtask : pin_reset
endmodule : lpmc_cpu_model

// ---- verification/lpmc_top_tb.sv ----
`timescale 1ns/10ps
`include "lpmc_consts.svh"
module lpmc_top_tb;
  import lpmc_pkg::*;
  logic                    clk;
  logic                    rst_b;
  logic [`LPMC_ADDR_W-1:0] addr;
  logic                    rd;
  logic                    wr;
  logic [31:0]             wdata;
  logic [3:0]              be;
  logic [31:0]             rdata;
  logic                    waitreq;
  lpmc_cpu_req_t           req;
  logic                    pin_n;
  lpmc_pwr_ctl_t           pwr;
  logic                    exc;
  logic                    dt_exc;
  logic                    prst;
  int                      mismatches;
  int                      samples_checked;
  lpmc_top #(.STBY_WAIT_MAX(16'h0010)) uut (
    .core_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .cpu_req_in(req),
    .chip_init_pin_n_in(pin_n), .pwr_ctl_out(pwr), .exc_start_out(exc),
    .dt_exc_start_out(dt_exc), .periph_reset_out(prst));
  lpmc_cpu_model cpu (
    .core_clk_in(clk), .pwr_ctl_in(pwr), .exc_start_in(exc), .dt_exc_start_in(dt_exc),
    .cpu_req_out(req), .chip_init_pin_n_out(pin_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_of_test();
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_val({31'h0, got}, {31'h0, exp}, m);
  endtask : chk_bit
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= {24'h0, d};
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg
  task automatic chk_reg(input logic [1:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk_val(q, e, m);
  endtask : chk_reg
  task automatic chk_mode(input logic [2:0] e);
    logic [31:0] q;
    bus(1'b0, `LPMC_OFS_STATUS, 8'h00, q);
    chk_val({29'h0, q[2:0]}, {29'h0, e}, "mode");
  endtask : chk_mode
  task automatic wait_pulse(input logic dt, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((dt ? dt_exc : exc) !== 1'b1 && n < 60);
  endtask : wait_pulse
  task automatic t_reset();
    chk_reg(`LPMC_OFS_CTRL_FIRST, 32'h0, "ctrl first reset");
    chk_reg(`LPMC_OFS_CTRL_SECOND, 32'h0, "ctrl second reset");
    wr_reg(2'h3, 8'hFF);
    chk_reg(2'h3, 32'h0, "unmapped read");
    be <= 4'h0;
    wr_reg(`LPMC_OFS_CTRL_FIRST, 8'hFF);
    be <= 4'h1;
    chk_reg(`LPMC_OFS_CTRL_FIRST, 32'h0, "lane off write");
    chk_mode(`LPMC_MODE_ACTIVE);
    chk_bit(pwr.cpu_run, 1'b1, "run after reset");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_sleep();
    wr_reg(`LPMC_OFS_CTRL_SECOND, 8'h14);
    chk_val({29'h0, pwr.active_speed}, 32'h0, "speed before sleep");
    cpu.set_flags(1'b1, 1'b0);
    cpu.sleep_insn();
    chk_mode(`LPMC_MODE_SLEEP);
    chk_bit(pwr.cpu_run, 1'b0, "sleep halts cpu");
    chk_bit(pwr.periph_clk_en, 1'b1, "sleep periph clock");
    chk_val({29'h0, pwr.active_speed}, 32'h5, "speed after sleep");
    cpu.raise_irq();
    repeat (6) @(posedge clk);
    chk_mode(`LPMC_MODE_SLEEP);
    cpu.set_flags(1'b0, 1'b0);
    begin
      int n;
      wait_pulse(1'b0, n);
      chk_bit(n < 6, 1'b1, "sleep wake pulse");
    end
    chk_mode(`LPMC_MODE_ACTIVE);
    chk_bit(pwr.cpu_run, 1'b1, "wake runs cpu");
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_subsleep();
    int n;
    logic seen;
    seen = 1'b0;
    wr_reg(`LPMC_OFS_CTRL_FIRST, 8'h08);
    wr_reg(`LPMC_OFS_CTRL_SECOND, 8'h82);
    cpu.sleep_insn();
    repeat (4) begin
      @(posedge clk);
      if (prst === 1'b1) seen = 1'b1;
    end
    chk_bit(seen, 1'b1, "peripheral reset");
    chk_mode(`LPMC_MODE_SUBSLEEP);
    chk_bit(pwr.timer_a_run, 1'b1, "timer a runs");
    chk_bit(pwr.periph_clk_en, 1'b0, "periph halted");
    chk_bit(pwr.io_hold, 1'b1, "ports hold");
    chk_bit(pwr.cpu_run, 1'b0, "cpu halted");
    cpu.raise_irq();
    wait_pulse(1'b0, n);
    chk_bit(n < 6, 1'b1, "subsleep wake fast");
    chk_mode(`LPMC_MODE_SUBACT);
    chk_bit(pwr.clk_src_sub, 1'b1, "watch clock");
    chk_val({30'h0, pwr.sub_speed}, 32'h2, "sub speed");
    $display("t_subsleep done");
  endtask : t_subsleep
  task automatic t_direct();
    int n;
    wr_reg(`LPMC_OFS_CTRL_FIRST, 8'h10);
    wr_reg(`LPMC_OFS_CTRL_SECOND, 8'h2C);
    cpu.set_flags(1'b0, 1'b1);
    cpu.sleep_insn();
    wait_pulse(1'b1, n);
    chk_bit(n >= 10 && n <= 16, 1'b1, "sub to active time");
    chk_mode(`LPMC_MODE_ACTIVE);
    chk_bit(pwr.clk_src_sub, 1'b0, "system clock");
    chk_val({29'h0, pwr.active_speed}, 32'h3, "new active speed");
    wr_reg(`LPMC_OFS_CTRL_FIRST, 8'h08);
    wr_reg(`LPMC_OFS_CTRL_SECOND, 8'h21);
    cpu.sleep_insn();
    wait_pulse(1'b1, n);
    chk_bit(n >= 2 && n <= 6, 1'b1, "active to sub time");
    chk_mode(`LPMC_MODE_SUBACT);
    chk_val({30'h0, pwr.sub_speed}, 32'h1, "sub speed four");
    chk_bit(pwr.cpu_run, 1'b1, "program not halted");
    wr_reg(`LPMC_OFS_CTRL_FIRST, 8'h00);
    wr_reg(`LPMC_OFS_CTRL_SECOND, 8'h20);
    cpu.set_flags(1'b0, 1'b0);
    cpu.sleep_insn();
    chk_mode(`LPMC_MODE_SLEEP);
    chk_val({30'h0, pwr.sub_speed}, 32'h0, "sub speed two");
    cpu.raise_irq();
    wait_pulse(1'b0, n);
    chk_bit(n < 6, 1'b1, "fallback sleep wake");
    chk_mode(`LPMC_MODE_ACTIVE);
    $display("t_direct done");
  endtask : t_direct
  task automatic t_standby();
    int n;
    wr_reg(`LPMC_OFS_CTRL_FIRST, 8'h90);
    wr_reg(`LPMC_OFS_CTRL_SECOND, 8'h80);
    cpu.sleep_insn();
    chk_mode(`LPMC_MODE_STANDBY);
    chk_bit(pwr.io_hiz, 1'b1, "ports high z");
    chk_bit(pwr.sys_osc_en, 1'b0, "clock stopped");
    chk_bit(pwr.periph_clk_en | pwr.cpu_run, 1'b0, "all halted");
    cpu.raise_irq();
    wait_pulse(1'b0, n);
    chk_bit(n >= 8 && n <= 12, 1'b1, "settling wait");
    chk_mode(`LPMC_MODE_ACTIVE);
    chk_bit(pwr.io_hiz, 1'b0, "ports released");
    $display("t_standby done");
  endtask : t_standby
  task automatic t_lock();
    int n;
    wr_reg(`LPMC_OFS_CTRL_FIRST, 8'h00);
    wr_reg(`LPMC_OFS_CTRL_SECOND, 8'h20);
    cpu.set_flags(1'b1, 1'b1);
    cpu.sleep_insn();
    chk_mode(`LPMC_MODE_SLEEP);
    cpu.set_flags(1'b0, 1'b1);
    cpu.raise_irq();
    repeat (8) @(posedge clk);
    chk_mode(`LPMC_MODE_SLEEP);
    cpu.pin_reset();
    repeat (3) @(posedge clk);
    chk_mode(`LPMC_MODE_ACTIVE);
    chk_bit(pwr.cpu_reset, 1'b0, "reset released");
    chk_bit(pwr.cpu_run, 1'b1, "cpu restarts");
    cpu.sleep_insn();
    wait_pulse(1'b1, n);
    chk_bit(n >= 2 && n <= 6, 1'b1, "active to active time");
    chk_mode(`LPMC_MODE_ACTIVE);
    $display("t_lock done");
  endtask : t_lock
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    addr = '0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = '0;
    be = 4'h1;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sleep();
    t_subsleep();
    t_direct();
    t_standby();
    t_lock();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule : lpmc_top_tb
